// file: rtl/aem_manager.sv
// Purpose: alert escalation manager for a dual heading-sensor panel
// Assumes: one alert event per source is held until serviced
// Notes: lower-priority pending events wait; a newer event overwrites
`timescale 1ns/1ps
module aem_manager #(
   parameter int unsigned N = aem_pkg::SLOTS,
   parameter int unsigned SEC_CYCLES = aem_pkg::SEC_CYCLES,
   parameter int unsigned HOLD_CYCLES = aem_pkg::HOLD_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input aem_pkg::aem_gyro_t gyro1_i,
   input aem_pkg::aem_gyro_t gyro2_i,
   input aem_pkg::aem_fault_t fault_i,
   input wire logic ack_key_i,
   input aem_pkg::aem_ack_t ext_ack_i,
   output logic window_open_o,
   output logic [9:0] window_code_o,
   output logic blink_o,
   output logic [$clog2(N+1)-1:0] count_o,
   output logic count_blink_o,
   output logic buzzer_o,
   output logic fwd_valid_o,
   output logic [9:0] fwd_code_o,
   output aem_pkg::aem_entry_t [N-1:0] list_o
);

   localparam int CW = $clog2(N + 1);

   if (N < 2 || N > 64 || SEC_CYCLES < 2 || HOLD_CYCLES < 3) begin : g_chk
      $error("aem_manager: unsupported parameter values");
   end

   logic [1:0] rst_q;
   logic rst_n;
   aem_pkg::aem_gyro_t pend_g1, pend_g2;
   aem_pkg::aem_fault_t pend_f;
   logic [2:0] take;
   logic ev_valid, ev_raise;
   aem_pkg::aem_alert_t ev_alert;
   aem_pkg::aem_xlat_t x1, x2;
   logic [31:0] sec_cnt, hold_cnt, key_run;
   logic tick, phase, key_q, press, hold_done, panel_ack;
   aem_pkg::aem_alert_t info_v [N];
   aem_pkg::aem_state_t state_v [N];
   logic [N-1:0] used_v, unack_v, cause_v, sound_v, fwd_v, match_v, alloc_v;
   logic [N-1:0] ack_v, ext_hit_v, cat_b_v;
   logic [CW-1:0] n_unack, n_used;
   logic [9:0] first_code, fwd_code;

   // ***************************************
   // Reset release and second tick
   // ***************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sec_cnt <= 32'h0;
         tick <= 1'b0;
         phase <= 1'b0;
      end else begin
         tick <= (sec_cnt == SEC_CYCLES - 1);
         sec_cnt <= (sec_cnt == SEC_CYCLES - 1) ? 32'h0 : sec_cnt + 32'h1;
         if (tick) begin
            phase <= !phase;
         end
      end
   end

   // ***************************************
   // Event intake
   // ***************************************
   assign take[0] = pend_g1.valid;
   assign take[1] = pend_g2.valid && !take[0];
   assign take[2] = pend_f.valid && !take[0] && !take[1];

   // New event wins over the clear of a serviced one
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pend_g1 <= '0;
         pend_g2 <= '0;
         pend_f <= '0;
      end else begin
         if (gyro1_i.valid) pend_g1 <= gyro1_i;
         else if (take[0]) pend_g1.valid <= 1'b0;
         if (gyro2_i.valid) pend_g2 <= gyro2_i;
         else if (take[1]) pend_g2.valid <= 1'b0;
         if (fault_i.valid) pend_f <= fault_i;
         else if (take[2]) pend_f.valid <= 1'b0;
      end
   end

   assign x1 = aem_pkg::aem_gyro_xlate(1'b0, pend_g1.char_code);
   assign x2 = aem_pkg::aem_gyro_xlate(1'b1, pend_g2.char_code);

   always_comb begin
      ev_valid = 1'b0;
      ev_raise = 1'b0;
      ev_alert = '0;
      if (take[0]) begin
         ev_valid = x1.ok;
         ev_raise = pend_g1.raise;
         ev_alert = x1.alert;
      end else if (take[1]) begin
         ev_valid = x2.ok;
         ev_raise = pend_g2.raise;
         ev_alert = x2.alert;
      end else if (take[2]) begin
         ev_valid = 1'b1;
         ev_raise = pend_f.raise;
         ev_alert = pend_f.alert;
      end
   end

   // ***************************************
   // Slot selection and acknowledge routing
   // ***************************************
   always_comb begin
      logic found;
      found = 1'b0;
      alloc_v = '0;
      for (int i = 0; i < N; i++) begin
         used_v[i] = state_v[i] != aem_pkg::ST_FREE;
         unack_v[i] = state_v[i] == aem_pkg::ST_WARN || state_v[i] == aem_pkg::ST_ALARM;
         cat_b_v[i] = info_v[i].cat_b;
         match_v[i] = ev_valid && used_v[i] && info_v[i].code == ev_alert.code;
         ext_hit_v[i] = ext_ack_i.valid && info_v[i].code == ext_ack_i.code;
      end
      for (int i = 0; i < N; i++) begin
         if (ev_valid && ev_raise && match_v == '0 && !used_v[i] && !found) begin
            alloc_v[i] = 1'b1;
            found = 1'b1;
         end
      end
   end

   assign press = ack_key_i && !key_q;
   // press for one, hold for several
   assign panel_ack = (press && n_unack == CW'(1)) || (hold_done && n_unack > CW'(1));
   // external acknowledge only for category B
   assign ack_v = unack_v & ({N{panel_ack}} | (ext_hit_v & cat_b_v));

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         key_q <= 1'b0;
         hold_cnt <= 32'h0;
         hold_done <= 1'b0;
      end else begin
         key_q <= ack_key_i;
         hold_done <= ack_key_i && key_q && hold_cnt == HOLD_CYCLES - 2;
         if (!ack_key_i) hold_cnt <= 32'h0;
         else if (hold_cnt != HOLD_CYCLES - 1) hold_cnt <= hold_cnt + 32'h1;
      end
   end

   for (genvar i = 0; i < N; i++) begin : g_slot
      aem_slot u_slot (
         .clk_i(clk_i),
         .rst_n_i(rst_n),
         .tick_i(tick),
         .alloc_i(alloc_v[i]),
         .info_i(ev_alert),
         .ack_i(ack_v[i]),
         .cause_set_i(match_v[i] && ev_raise),
         .cause_clr_i(match_v[i] && !ev_raise),
         .info_o(info_v[i]),
         .state_o(state_v[i]),
         .cause_o(cause_v[i]),
         .sound_o(sound_v[i]),
         .fwd_o(fwd_v[i])
      );
   end

   // ***************************************
   // Panel outputs
   // ***************************************
   always_comb begin
      n_unack = '0;
      n_used = '0;
      first_code = 10'h000;
      fwd_code = 10'h000;
      for (int i = N - 1; i >= 0; i--) begin
         n_unack = n_unack + {{(CW-1){1'b0}}, unack_v[i]};
         n_used = n_used + {{(CW-1){1'b0}}, used_v[i]};
         if (unack_v[i]) first_code = info_v[i].code;
         if (fwd_v[i]) fwd_code = info_v[i].code;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         window_open_o <= 1'b0;
         window_code_o <= 10'h000;
         blink_o <= 1'b0;
         count_o <= '0;
         count_blink_o <= 1'b0;
         buzzer_o <= 1'b0;
      end else begin
         // window, count and buzzer follow entries
         window_open_o <= |unack_v;
         window_code_o <= first_code;
         count_o <= n_used;
         blink_o <= |unack_v && phase;
         count_blink_o <= |unack_v && phase;
         buzzer_o <= |sound_v;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         fwd_valid_o <= 1'b0;
         fwd_code_o <= 10'h000;
      end else begin
         fwd_valid_o <= |fwd_v;
         fwd_code_o <= fwd_code;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         list_o <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            list_o[i] <= {used_v[i], state_v[i] == aem_pkg::ST_ACKED, cause_v[i],
               info_v[i].code};
         end
      end
   end

   // ***************************************
   // Checks
   // ***************************************
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         key_run <= 32'h0;
      end else begin
         key_run <= ack_key_i ? key_run + 32'h1 : 32'h0;
      end
   end

   sequence alloc_no_ack_s;
      |alloc_v ##1 ack_v == '0;
   endsequence

   alert_opens_a: assert property (
      alloc_no_ack_s |=> window_open_o && buzzer_o && count_o != '0)
      else $error("new alert did not open window and buzzer");

   single_press_a: assert property (
      press && n_unack == CW'(1) && alloc_v == '0 |=> n_unack == '0)
      else $error("single press did not acknowledge lone alert");

   multi_hold_a: assert property (
      n_unack > CW'(1) && key_run != HOLD_CYCLES - 1 && !ext_ack_i.valid
      |=> ($past(unack_v) & ~unack_v) == '0)
      else $error("several alerts acknowledged without hold");

   ack_quiet_a: assert property (
      panel_ack && alloc_v == '0 ##1 alloc_v == '0
      |=> !window_open_o && !buzzer_o && !count_blink_o)
      else $error("acknowledge left window or buzzer on");

   cat_a_panel_a: assert property (
      !ack_key_i && key_run != HOLD_CYCLES - 1 |=> ($past(unack_v & ~cat_b_v) & ~unack_v) == '0)
      else $error("category A acknowledged externally");

   gyro_range_a: assert property (
      take[0] && ev_valid |-> ev_alert.code >= 10'h12C && ev_alert.code <= 10'h141
      && !ev_alert.escal)
      else $error("unit one code out of range");

endmodule // aem_manager

// file: rtl/aem_pkg.sv
// Purpose: shared types and constants of the alert escalation manager
// Assumes: 125 MHz system clock, alert timing counted in whole seconds
// Notes: gyro fault characters map to panel codes through aem_gyro_xlate
package aem_pkg;

   // ***************************************
   // Timing
   // ***************************************
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned SEC_NS = 1_000_000_000;
   localparam int unsigned SEC_CYCLES = SEC_NS / (SEC_NS / CLK_HZ);
   localparam int unsigned HOLD_S = 3;
   localparam int unsigned HOLD_CYCLES = HOLD_S * SEC_CYCLES;
   localparam logic [5:0] ESC_S = 6'h3C;
   localparam logic [5:0] FWD_S = 6'h1E;
   localparam int unsigned SLOTS = 8;

   // ***************************************
   // Panel codes
   // ***************************************
   localparam logic [9:0] GYRO1_BASE = 10'h12C;
   localparam logic [9:0] GYRO2_BASE = 10'h1F4;
   localparam logic [9:0] GYRO_SPAN = 10'h015;

   // ***************************************
   // Types
   // ***************************************
   typedef enum logic [3:0] {
      ST_FREE = 4'h1,
      ST_WARN = 4'h2,
      ST_ALARM = 4'h4,
      ST_ACKED = 4'h8
   } aem_state_t;

   typedef struct packed {
      logic [9:0] code;
      logic cat_b;
      logic escal;
   } aem_alert_t;

   typedef struct packed {
      logic valid;
      logic raise;
      logic [7:0] char_code;
   } aem_gyro_t;

   typedef struct packed {
      logic valid;
      logic raise;
      aem_alert_t alert;
   } aem_fault_t;

   typedef struct packed {
      logic valid;
      logic [9:0] code;
   } aem_ack_t;

   typedef struct packed {
      logic used;
      logic acked;
      logic cause;
      logic [9:0] code;
   } aem_entry_t;

   typedef struct packed {
      logic ok;
      aem_alert_t alert;
   } aem_xlat_t;

   // Fault character to panel code; gyro faults never escalate
   function automatic aem_xlat_t aem_gyro_xlate(logic unit2, logic [7:0] ch);
      aem_xlat_t r;
      logic [9:0] off;
      r = '0;
      off = 10'h000;
      r.ok = 1'b1;
      case (ch)
         8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37: off = {2'h0, ch - 8'h31};
         8'h39: off = 10'h007;
         8'h41: off = 10'h008;
         8'h62: off = 10'h009;
         8'h43, 8'h63: off = 10'h00A;
         8'h64: off = 10'h00B;
         8'h50: off = 10'h00C;
         8'h55: off = 10'h00D;
         8'h72: off = 10'h012;
         8'h47: off = 10'h013;
         8'h38: off = 10'h014;
         8'h4A: off = 10'h015;
         default: r.ok = 1'b0;
      endcase
      case (ch)
         8'h39, 8'h43, 8'h63, 8'h64, 8'h50, 8'h55, 8'h38: r.alert.cat_b = 1'b1;
         default: r.alert.cat_b = 1'b0;
      endcase
      r.alert.code = (unit2 ? GYRO2_BASE : GYRO1_BASE) + off;
      r.alert.escal = 1'b0;
      return r;
   endfunction

endpackage

// file: rtl/aem_slot.sv
// Purpose: one alert entry with its escalation timers
// Assumes: tick_i is a one-cycle pulse once per second
// Notes: entry stays after acknowledgement while its cause is present
`timescale 1ns/1ps
module aem_slot (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic alloc_i,
   input aem_pkg::aem_alert_t info_i,
   input wire logic ack_i,
   input wire logic cause_set_i,
   input wire logic cause_clr_i,
   output aem_pkg::aem_alert_t info_o,
   output aem_pkg::aem_state_t state_o,
   output logic cause_o,
   output logic sound_o,
   output logic fwd_o
);

   logic [5:0] secs;
   logic rearm;

   assign rearm = (state_o == aem_pkg::ST_WARN) && !ack_i && tick_i
      && (secs == aem_pkg::ESC_S - 6'h01);

   // ***************************************
   // Entry state and seconds
   // ***************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_o <= aem_pkg::ST_FREE;
         secs <= 6'h00;
      end else begin
         case (state_o)
            aem_pkg::ST_FREE: begin
               secs <= 6'h00;
               if (alloc_i) begin
                  state_o <= aem_pkg::ST_WARN;
               end
            end
            aem_pkg::ST_WARN: begin
               if (ack_i) begin
                  state_o <= aem_pkg::ST_ACKED;
               end else if (rearm) begin
                  secs <= 6'h00;
                  if (info_o.escal) begin
                     state_o <= aem_pkg::ST_ALARM;
                  end
               end else if (tick_i) begin
                  secs <= secs + 6'h01;
               end
            end
            aem_pkg::ST_ALARM: begin
               if (ack_i) begin
                  state_o <= aem_pkg::ST_ACKED;
               end else if (tick_i && secs != aem_pkg::FWD_S) begin
                  secs <= secs + 6'h01;
               end
            end
            aem_pkg::ST_ACKED: begin
               if (!cause_o) begin
                  state_o <= aem_pkg::ST_FREE;
               end
            end
            default: state_o <= aem_pkg::ST_FREE;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         info_o <= '0;
      end else if (alloc_i && state_o == aem_pkg::ST_FREE) begin
         info_o <= info_i;
      end
   end

   // Set wins over clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cause_o <= 1'b0;
      end else if (alloc_i || cause_set_i) begin
         cause_o <= 1'b1;
      end else if (cause_clr_i) begin
         cause_o <= 1'b0;
      end
   end

   // ***************************************
   // Buzzer request and forwarding
   // ***************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sound_o <= 1'b0;
      end else if (state_o == aem_pkg::ST_FREE) begin
         sound_o <= alloc_i;
      end else if (ack_i) begin
         sound_o <= 1'b0;
      end else if (rearm && !info_o.escal) begin
         sound_o <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fwd_o <= 1'b0;
      end else begin
         fwd_o <= (state_o == aem_pkg::ST_ALARM) && !ack_i && tick_i
            && (secs == aem_pkg::FWD_S - 6'h01);
      end
   end

   // ***************************************
   // Checks
   // ***************************************
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence warn_expiry_s;
      state_o == aem_pkg::ST_WARN && tick_i && !ack_i && secs == 6'h3B;
   endsequence

   escalate_time_a: assert property (
      state_o == aem_pkg::ST_WARN ##1 state_o == aem_pkg::ST_ALARM
      |-> $past(tick_i) && $past(secs) == 6'h3B && info_o.escal)
      else $error("warning escalated at wrong time");

   forward_time_a: assert property (
      fwd_o |-> $past(state_o) == aem_pkg::ST_ALARM && $past(secs) == 6'h1D)
      else $error("alarm forwarded at wrong time");

   resound_warn_a: assert property (
      warn_expiry_s ##0 !info_o.escal |=> sound_o && secs == 6'h00
      && state_o == aem_pkg::ST_WARN)
      else $error("warning did not re-sound");

   ack_retain_a: assert property (
      state_o == aem_pkg::ST_ACKED && cause_o && !cause_clr_i
      |=> state_o == aem_pkg::ST_ACKED && !sound_o)
      else $error("acknowledged entry lost while cause present");

endmodule // aem_slot

// file: testbench/aem_panel_model.sv
// Purpose: operator panel and external alert manager model
// Assumes: requests change just after the falling edge of clk_i
// Notes: forwarded alarms are counted and latched for the bench
`timescale 1ns/1ps
module aem_panel_model (
   input wire logic clk_i,
   input wire logic fwd_valid_i,
   input wire logic [9:0] fwd_code_i,
   output logic ack_key_o,
   output aem_pkg::aem_ack_t ext_ack_o
);
   int fwd_seen = 0;
   logic [9:0] fwd_last = 10'h000;

   initial begin
      ack_key_o = 1'b0;
      ext_ack_o = '0;
   end

   always @(posedge clk_i) begin
      if (fwd_valid_i === 1'b1) begin
         fwd_seen <= fwd_seen + 1;
         fwd_last <= fwd_code_i;
      end
   end

   // key held for a number of cycles
   task automatic key(input int cycles);
      @(negedge clk_i);
      ack_key_o = 1'b1;
      repeat (cycles) @(negedge clk_i);
      ack_key_o = 1'b0;
      repeat (2) @(negedge clk_i);
   endtask

   // one-cycle acknowledge; code line inverted once released
   task automatic ext_ack(input logic [9:0] code);
      @(negedge clk_i);
      ext_ack_o = '{valid: 1'b1, code: code};
      @(negedge clk_i);
      ext_ack_o = '{valid: 1'b0, code: ~code};
   endtask
endmodule // aem_panel_model

// file: testbench/aem_manager_tb_top.sv
// Purpose: self-checking bench of the alert escalation manager
// Assumes: one second shortened to 10 cycles, hold to 30 cycles
// Notes: inputs change on the falling edge of clk_i
`timescale 1ns/1ps
module aem_manager_tb_top;
   localparam int unsigned N = 8;
   localparam int unsigned SEC = 10;
   localparam int unsigned HOLD = 30;
   localparam int LIMIT = 8000;
   logic clk_i, rst_n_i, ack_key, win, blink, cblink, buzzer, fwd_valid;
   logic [9:0] win_code, fwd_code;
   logic [3:0] count;
   aem_pkg::aem_gyro_t gyro1, gyro2;
   aem_pkg::aem_fault_t fault;
   aem_pkg::aem_ack_t ext_ack;
   aem_pkg::aem_entry_t [N-1:0] list;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [7:0] map_ch [20] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h39, 8'h41,
      8'h62, 8'h43, 8'h63, 8'h64, 8'h50, 8'h55, 8'h72, 8'h47, 8'h38, 8'h4A, 8'h33};
   logic [9:0] map_off [20] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h004, 10'h005, 10'h006,
      10'h007, 10'h008, 10'h009, 10'h00A, 10'h00A, 10'h00B, 10'h00C, 10'h00D, 10'h012, 10'h013,
      10'h014, 10'h015, 10'h002};
   logic map_b [20] = '{0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 1, 1, 1, 1, 1, 0, 0, 1, 0, 0};

   aem_manager #(.N(N), .SEC_CYCLES(SEC), .HOLD_CYCLES(HOLD)) DUT (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .gyro1_i(gyro1), .gyro2_i(gyro2), .fault_i(fault),
      .ack_key_i(ack_key), .ext_ack_i(ext_ack), .window_open_o(win), .window_code_o(win_code),
      .blink_o(blink), .count_o(count), .count_blink_o(cblink), .buzzer_o(buzzer),
      .fwd_valid_o(fwd_valid), .fwd_code_o(fwd_code), .list_o(list));

   aem_panel_model u_panel (.clk_i(clk_i), .fwd_valid_i(fwd_valid), .fwd_code_i(fwd_code),
      .ack_key_o(ack_key), .ext_ack_o(ext_ack));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // ***************************************
   // Checking helpers
   // ***************************************
   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_code(input logic [9:0] got, input logic [9:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_listed(input logic [9:0] code, input logic acked, input logic cause);
      int i;
      logic hit;
      hit = 1'b0;
      for (i = 0; i < N; i++) begin
         if (list[i].used === 1'b1 && list[i].code === code) begin
            hit = 1'b1;
            chk_bit(list[i].acked, acked);
            chk_bit(list[i].cause, cause);
         end
      end
      chk_bit(hit, 1'b1);
   endtask

   task automatic wait_win(input logic exp, input int max);
      int i;
      for (i = 0; i < max && win !== exp; i++) @(negedge clk_i);
      chk_bit(win, exp);
   endtask

   task automatic gyro_ev(input logic unit2, input logic raise, input logic [7:0] ch);
      @(negedge clk_i);
      if (unit2) begin
         gyro2 = '{valid: 1'b1, raise: raise, char_code: ch};
      end else begin
         gyro1 = '{valid: 1'b1, raise: raise, char_code: ch};
      end
      @(negedge clk_i);
      gyro1.valid = 1'b0;
      gyro2.valid = 1'b0;
      repeat (6) @(negedge clk_i);
   endtask

   task automatic fault_ev(input logic raise, input logic [9:0] code, input logic cat_b,
      input logic escal);
      @(negedge clk_i);
      fault = '{valid: 1'b1, raise: raise, alert: '{code: code, cat_b: cat_b, escal: escal}};
      @(negedge clk_i);
      fault.valid = 1'b0;
      repeat (6) @(negedge clk_i);
   endtask

   // ***************************************
   // Scenarios
   // ***************************************
   // lone alert life cycle
   task automatic t_single;
      logic b;
      gyro_ev(1'b0, 1'b1, 8'h31);
      wait_win(1'b1, 4);
      chk_code(win_code, 10'h12C);
      chk_bit(buzzer, 1'b1);
      chk_code({6'h00, count}, 10'h001);
      b = blink;
      repeat (SEC) @(negedge clk_i);
      chk_bit(blink, ~b);
      chk_bit(cblink, ~b);
      u_panel.key(1);
      chk_bit(win, 1'b0);
      chk_bit(buzzer, 1'b0);
      chk_bit(cblink, 1'b0);
      chk_listed(10'h12C, 1'b1, 1'b1);
      chk_code({6'h00, count}, 10'h001);
      gyro_ev(1'b0, 1'b0, 8'h31);
      chk_code({6'h00, count}, 10'h000);
      $display("t_single done");
   endtask

   // several alerts need the held key
   task automatic t_multi;
      gyro_ev(1'b0, 1'b1, 8'h39);
      gyro_ev(1'b1, 1'b1, 8'h33);
      chk_code({6'h00, count}, 10'h002);
      u_panel.key(1);
      repeat (3) @(negedge clk_i);
      chk_bit(win, 1'b1);
      u_panel.key(HOLD + 2);
      chk_bit(win, 1'b0);
      chk_listed(10'h133, 1'b1, 1'b1);
      chk_listed(10'h1F6, 1'b1, 1'b1);
      gyro_ev(1'b0, 1'b0, 8'h39);
      gyro_ev(1'b1, 1'b0, 8'h33);
      chk_code({6'h00, count}, 10'h000);
      $display("t_multi done");
   endtask

   // escalating warning reaches the alert manager
   task automatic t_escalate;
      int n0;
      n0 = u_panel.fwd_seen;
      fault_ev(1'b1, 10'h0F0, 1'b1, 1'b1);
      repeat (85 * SEC - 8) @(negedge clk_i);
      chk_code(u_panel.fwd_seen - n0, 10'h000);
      repeat (7 * SEC) @(negedge clk_i);
      chk_code(u_panel.fwd_seen - n0, 10'h001);
      chk_code(u_panel.fwd_last, 10'h0F0);
      chk_bit(buzzer, 1'b1);
      u_panel.ext_ack(10'h0F0);
      wait_win(1'b0, 4);
      fault_ev(1'b0, 10'h0F0, 1'b1, 1'b1);
      $display("t_escalate done");
   endtask

   // non-escalating category A fault keeps sounding, stays listed
   task automatic t_resound;
      int n0;
      n0 = u_panel.fwd_seen;
      fault_ev(1'b1, 10'h0F1, 1'b0, 1'b0);
      repeat (95 * SEC) @(negedge clk_i);
      chk_code(u_panel.fwd_seen - n0, 10'h000);
      chk_bit(buzzer, 1'b1);
      chk_bit(win, 1'b1);
      u_panel.ext_ack(10'h0F1);
      repeat (4) @(negedge clk_i);
      chk_bit(win, 1'b1);
      fault_ev(1'b0, 10'h0F1, 1'b0, 1'b0);
      chk_listed(10'h0F1, 1'b0, 1'b0);
      u_panel.key(1);
      chk_bit(win, 1'b0);
      chk_code({6'h00, count}, 10'h000);
      $display("t_resound done");
   endtask

   // every fault character of both units
   task automatic t_map;
      int u;
      int k;
      logic [9:0] base;
      for (u = 0; u < 2; u++) begin
         base = (u == 1) ? 10'h1F4 : 10'h12C;
         for (k = 0; k < 20; k++) begin
            gyro_ev(u[0], 1'b1, map_ch[k]);
            chk_code(win_code, base + map_off[k]);
            u_panel.ext_ack(base + map_off[k]);
            repeat (3) @(negedge clk_i);
            chk_bit(win, ~map_b[k]);
            if (win === 1'b1) begin
               u_panel.key(1);
            end
            gyro_ev(u[0], 1'b0, map_ch[k]);
            chk_code({6'h00, count}, 10'h000);
         end
      end
      $display("t_map done");
   endtask

   // ***************************************
   // Run control
   // ***************************************
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == LIMIT) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, cyc, LIMIT);
         stop_test();
      end
   end

   initial begin
      rst_n_i = 1'b0;
      gyro1 = '0;
      gyro2 = '0;
      fault = '0;
      repeat (5) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (3) @(negedge clk_i);
      t_single();
      t_multi();
      t_escalate();
      t_resound();
      t_map();
      stop_test();
   end
endmodule // aem_manager_tb_top
